/* File: verilog/cosd_pkg.sv */
/*
 * cosd_pkg: constants for the command-only subcommand decoder.
 * Assumes a 10 MHz core clock; every cycle count is derived from it here.
 */
`default_nettype none
package cosd_pkg;

	localparam int unsigned CODE_W     = 16;
	localparam int unsigned PIN_COUNT  = 6;
	localparam int unsigned COMM_W     = 8;
	localparam int unsigned ACTIVE_W   = 8;
	localparam int unsigned SEC_W      = 2;
	localparam int unsigned CNT_W      = 32;

	// subcommand codes
	localparam logic [15:0] CODE_RECOVER_OVERCURRENT = 16'h009b;
	localparam logic [15:0] CODE_RECOVER_SHORT       = 16'h009c;
	localparam logic [15:0] CODE_LOAD_SENSE_RESTART  = 16'h009d;
	localparam logic [15:0] CODE_LOAD_SENSE_ON       = 16'h009e;
	localparam logic [15:0] CODE_LOAD_SENSE_OFF      = 16'h009f;
	localparam logic [15:0] CODE_FORCED_WORD_ONE     = 16'h2857;
	localparam logic [15:0] CODE_FORCED_WORD_TWO     = 16'h29a3;
	localparam logic [15:0] CODE_SWAP_STORED         = 16'h29bc;
	localparam logic [15:0] CODE_SWITCH_TWO_WIRE     = 16'h29e7;
	localparam logic [15:0] CODE_SWITCH_FOUR_WIRE    = 16'h7c35;
	localparam logic [15:0] CODE_SWITCH_SINGLE_WIRE  = 16'h7c40;

	// pin order: charge-off in, discharge-off in, alert, link, charge drv, discharge drv
	localparam logic [15:0] PIN_LOW_CODE [PIN_COUNT] = '{
		16'h2800, 16'h2801, 16'h2802, 16'h2806, 16'h2807, 16'h2808};
	localparam logic [15:0] PIN_HIGH_CODE [PIN_COUNT] = '{
		16'h2810, 16'h2811, 16'h2812, 16'h2816, 16'h2817, 16'h2818};
	localparam int unsigned PIN_ALERT = 2;

	// security states; sealed is the most restricted
	localparam logic [1:0] SEC_SEALED      = 2'h0;
	localparam logic [1:0] SEC_UNSEALED    = 2'h1;
	localparam logic [1:0] SEC_FULL_ACCESS = 2'h2;

	// interface type values held in configuration memory
	localparam logic [7:0] COMM_TWO_WIRE_FAST = 8'h08;
	localparam logic [7:0] COMM_FOUR_WIRE_CRC = 8'h10;
	localparam logic [7:0] COMM_SINGLE_WIRE   = 8'h03;
	localparam logic [7:0] COMM_RESET_VALUE   = COMM_TWO_WIRE_FAST;

	// timing
	localparam int unsigned CLK_KHZ              = 10000;
	localparam int unsigned SAFETY_PERIOD_MS     = 1000;
	localparam int unsigned FORCED_WINDOW_MS     = 4000;
	localparam int unsigned SAFETY_PERIOD_CYCLES = SAFETY_PERIOD_MS * CLK_KHZ;
	localparam int unsigned FORCED_WINDOW_CYCLES = FORCED_WINDOW_MS * CLK_KHZ;
	localparam int unsigned LOAD_SENSE_PASSES    = 8;

	typedef enum logic [0:0] {COSD_PF_IDLE, COSD_PF_ARMED} cosd_pf_state_t;

endpackage
`default_nettype wire

/* File: verilog/cosd_decoder.sv */
/*
 * cosd_decoder: acts on 16-bit command-only subcommand codes.
 * Assumes every input comes from logic on mclk_in (the subcommand transport,
 * safety engine and configuration store), so no synchronisers are needed.
 */
// Functional notes
// - code 0x009b clears the discharge overcurrent latch at the next one-second safety pass.
// - code 0x009c clears the discharge short-circuit latch at the next safety pass.
// - code 0x009d restarts the load-sense source timeout only if that timeout has expired.
// - codes 0x009e and 0x009f force the load-sense source on or off unless active time is set.
// - codes 0x2800-0x2808 drive the six general-output pins low where configured as outputs.
// - codes 0x2810-0x2818 drive the same six pins high where configured as outputs.
// - forced failure happens only on 0x2857 then 0x29a3 within 4 s with no write between.
// - code 0x29bc switches the active interface to the type held in configuration memory.
// - code 0x29e7 stores type 8 and switches to fast two-wire at once.
// - code 0x7c35 stores type 16 and switches to four-wire with check at once.
// - code 0x7c40 stores type 3 and switches to the single-wire link at once.
// - interface codes are refused while sealed; all other codes work in any state.
`timescale 1ns/1ps
`default_nettype none
module cosd_decoder
	import cosd_pkg::*;
#(
	parameter int unsigned SAFETY_CYCLES = cosd_pkg::SAFETY_PERIOD_CYCLES,
	parameter int unsigned WINDOW_CYCLES = cosd_pkg::FORCED_WINDOW_CYCLES,
	parameter int unsigned LS_PASSES     = cosd_pkg::LOAD_SENSE_PASSES
) (
	input  wire logic                          mclk_in,
	input  wire logic                          rstn_in,
	input  wire logic                          cmd_valid_in,
	input  wire logic [cosd_pkg::CODE_W-1:0]   cmd_code_in,
	input  wire logic                          other_write_in,
	input  wire logic [cosd_pkg::SEC_W-1:0]    security_state_in,
	input  wire logic                          overcurrent_set_in,
	input  wire logic                          short_set_in,
	input  wire logic [cosd_pkg::ACTIVE_W-1:0] load_sense_active_time_in,
	input  wire logic [cosd_pkg::PIN_COUNT-1:0] pin_is_output_in,
	input  wire logic [cosd_pkg::COMM_W-1:0]   comm_type_cfg_in,
	output logic                               cmd_done_out,
	output logic                               cmd_reject_out,
	output logic                               safety_pass_out,
	output logic                               dsg_overcurrent_latch_out,
	output logic                               dsg_short_latch_out,
	output logic                               load_sense_pin_out,
	output logic                               load_sense_expired_out,
	output logic [cosd_pkg::PIN_COUNT-1:0]     pin_level_out,
	output logic [cosd_pkg::PIN_COUNT-1:0]     pin_drive_out,
	output logic                               permanent_failure_out,
	output logic [cosd_pkg::COMM_W-1:0]        comm_type_out,
	output logic                               cfg_write_out,
	output logic [cosd_pkg::COMM_W-1:0]        cfg_write_data_out
);
	import cosd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic                 sealed;
	logic                 autonomous;
	logic                 is_rec_oc, is_rec_sc, is_ls_restart, is_ls_on, is_ls_off;
	logic                 is_word_one, is_word_two, is_swap, is_swap_two, is_swap_four;
	logic                 is_swap_single, swap_code, known;
	logic [PIN_COUNT-1:0] is_low, is_high;
	always_comb begin
		sealed         = (security_state_in == SEC_SEALED);
		autonomous     = (load_sense_active_time_in != '0);
		is_rec_oc      = cmd_valid_in && (cmd_code_in == CODE_RECOVER_OVERCURRENT);
		is_rec_sc      = cmd_valid_in && (cmd_code_in == CODE_RECOVER_SHORT);
		is_ls_restart  = cmd_valid_in && (cmd_code_in == CODE_LOAD_SENSE_RESTART);
		is_ls_on       = cmd_valid_in && (cmd_code_in == CODE_LOAD_SENSE_ON);
		is_ls_off      = cmd_valid_in && (cmd_code_in == CODE_LOAD_SENSE_OFF);
		is_word_one    = cmd_valid_in && (cmd_code_in == CODE_FORCED_WORD_ONE);
		is_word_two    = cmd_valid_in && (cmd_code_in == CODE_FORCED_WORD_TWO);
		is_swap        = cmd_valid_in && (cmd_code_in == CODE_SWAP_STORED);
		is_swap_two    = cmd_valid_in && (cmd_code_in == CODE_SWITCH_TWO_WIRE);
		is_swap_four   = cmd_valid_in && (cmd_code_in == CODE_SWITCH_FOUR_WIRE);
		is_swap_single = cmd_valid_in && (cmd_code_in == CODE_SWITCH_SINGLE_WIRE);
		for (int i = 0; i < PIN_COUNT; i++) begin
			is_low[i]  = cmd_valid_in && (cmd_code_in == PIN_LOW_CODE[i]);
			is_high[i] = cmd_valid_in && (cmd_code_in == PIN_HIGH_CODE[i]);
		end
		swap_code = is_swap || is_swap_two || is_swap_four || is_swap_single;
		known     = is_rec_oc || is_rec_sc || is_ls_restart || is_ls_on || is_ls_off ||
			is_word_one || is_word_two || swap_code || (|is_low) || (|is_high);
	end

	////////////////////////////////////////////////////////////////////////////
	// safety pass timebase and fault latches
	logic [CNT_W-1:0] tick_cnt, next_tick_cnt;
	logic             next_safety_pass;
	logic             oc_pending, next_oc_pending, sc_pending, next_sc_pending;
	logic             next_oc_latch, next_sc_latch;
	always_comb begin
		next_tick_cnt    = tick_cnt + 1'b1;
		next_safety_pass = 1'b0;
		if (tick_cnt == CNT_W'(SAFETY_CYCLES - 1)) begin
			next_tick_cnt    = '0;
			next_safety_pass = 1'b1;
		end
		next_oc_pending = oc_pending || is_rec_oc;
		next_sc_pending = sc_pending || is_rec_sc;
		next_oc_latch   = dsg_overcurrent_latch_out;
		next_sc_latch   = dsg_short_latch_out;
		if (safety_pass_out) begin
			if (oc_pending) begin
				next_oc_latch   = 1'b0;
				next_oc_pending = is_rec_oc;
			end
			if (sc_pending) begin
				next_sc_latch   = 1'b0;
				next_sc_pending = is_rec_sc;
			end
		end
		// a fresh fault wins over recovery
		next_oc_latch = next_oc_latch || overcurrent_set_in;
		next_sc_latch = next_sc_latch || short_set_in;
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_cnt                  <= '0;
			safety_pass_out           <= 1'b0;
			oc_pending                <= 1'b0;
			sc_pending                <= 1'b0;
			dsg_overcurrent_latch_out <= 1'b0;
			dsg_short_latch_out       <= 1'b0;
		end else begin
			tick_cnt                  <= next_tick_cnt;
			safety_pass_out           <= next_safety_pass;
			oc_pending                <= next_oc_pending;
			sc_pending                <= next_sc_pending;
			dsg_overcurrent_latch_out <= next_oc_latch;
			dsg_short_latch_out       <= next_sc_latch;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// load-sense current source, timed out after LS_PASSES safety passes
	logic [ACTIVE_W-1:0] ls_cnt, next_ls_cnt;
	logic                next_ls_on, next_ls_expired;
	always_comb begin
		next_ls_cnt     = ls_cnt;
		next_ls_on      = load_sense_pin_out;
		next_ls_expired = load_sense_expired_out;
		if (load_sense_pin_out && safety_pass_out) begin
			if (ls_cnt == '0) begin
				next_ls_on      = 1'b0;
				next_ls_expired = 1'b1;
			end else begin
				next_ls_cnt = ls_cnt - 1'b1;
			end
		end
		if ((is_ls_restart && load_sense_expired_out) ||
				(is_ls_on && !autonomous)) begin
			next_ls_on      = 1'b1;
			next_ls_expired = 1'b0;
			next_ls_cnt     = ACTIVE_W'(LS_PASSES - 1);
		end
		if (is_ls_off && !autonomous)
			next_ls_on = 1'b0;
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ls_cnt                 <= '0;
			load_sense_pin_out     <= 1'b0;
			load_sense_expired_out <= 1'b0;
		end else begin
			ls_cnt                 <= next_ls_cnt;
			load_sense_pin_out     <= next_ls_on;
			load_sense_expired_out <= next_ls_expired;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// general-output pins
	logic [PIN_COUNT-1:0] next_pin_level;
	always_comb begin
		next_pin_level = pin_level_out;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (is_low[i] && pin_is_output_in[i])
				next_pin_level[i] = 1'b0;
			if (is_high[i] && pin_is_output_in[i])
				next_pin_level[i] = 1'b1;
		end
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_level_out <= '0;
			pin_drive_out <= '0;
		end else begin
			pin_level_out <= next_pin_level;
			pin_drive_out <= pin_is_output_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-word forced failure
	cosd_pf_state_t   pf_state, next_pf_state;
	logic [CNT_W-1:0] pf_cnt, next_pf_cnt;
	logic             next_pf;
	always_comb begin
		next_pf_state = pf_state;
		next_pf_cnt   = pf_cnt;
		next_pf       = permanent_failure_out;
		case (pf_state)
			COSD_PF_IDLE: begin
				if (is_word_one) begin
					next_pf_state = COSD_PF_ARMED;
					next_pf_cnt   = CNT_W'(WINDOW_CYCLES - 1);
				end
			end
			COSD_PF_ARMED: begin
				next_pf_cnt = pf_cnt - 1'b1;
				if (is_word_two && !other_write_in) begin
					next_pf       = 1'b1;
					next_pf_state = COSD_PF_IDLE;
				end else if (is_word_one) begin
					next_pf_cnt = CNT_W'(WINDOW_CYCLES - 1);
				end else if (cmd_valid_in || other_write_in || pf_cnt == '0) begin
					next_pf_state = COSD_PF_IDLE;
				end
			end
			default: next_pf_state = COSD_PF_IDLE;
		endcase
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pf_state              <= COSD_PF_IDLE;
			pf_cnt                <= '0;
			permanent_failure_out <= 1'b0;
		end else begin
			pf_state              <= next_pf_state;
			pf_cnt                <= next_pf_cnt;
			permanent_failure_out <= next_pf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host interface selection and command answer
	logic              comm_loaded;
	logic [COMM_W-1:0] next_comm, next_cfg_data;
	logic              next_cfg_write, next_done, next_reject;
	always_comb begin
		next_comm      = comm_type_out;
		next_cfg_write = 1'b0;
		next_cfg_data  = cfg_write_data_out;
		if (!comm_loaded)
			next_comm = comm_type_cfg_in;
		if (!sealed) begin
			if (is_swap)
				next_comm = comm_type_cfg_in;
			if (is_swap_two)
				next_cfg_data = COMM_TWO_WIRE_FAST;
			if (is_swap_four)
				next_cfg_data = COMM_FOUR_WIRE_CRC;
			if (is_swap_single)
				next_cfg_data = COMM_SINGLE_WIRE;
			if (is_swap_two || is_swap_four || is_swap_single) begin
				next_comm      = next_cfg_data;
				next_cfg_write = 1'b1;
			end
		end
		next_reject = cmd_valid_in && (!known || (swap_code && sealed));
		next_done   = cmd_valid_in && !next_reject;
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			comm_loaded        <= 1'b0;
			comm_type_out      <= COMM_RESET_VALUE;
			cfg_write_out      <= 1'b0;
			cfg_write_data_out <= COMM_RESET_VALUE;
			cmd_done_out       <= 1'b0;
			cmd_reject_out     <= 1'b0;
		end else begin
			comm_loaded        <= 1'b1;
			comm_type_out      <= next_comm;
			cfg_write_out      <= next_cfg_write;
			cfg_write_data_out <= next_cfg_data;
			cmd_done_out       <= next_done;
			cmd_reject_out     <= next_reject;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_word_one;
		cmd_valid_in && cmd_code_in == CODE_FORCED_WORD_ONE;
	endsequence
	sequence s_quiet_then_two;
		(!cmd_valid_in && !other_write_in) [*3] ##1
			(cmd_valid_in && cmd_code_in == CODE_FORCED_WORD_TWO && !other_write_in);
	endsequence
	oc_recover_a: assert property (
		(is_rec_oc && !oc_pending) ##1 (!safety_pass_out && !overcurrent_set_in) [*2]
		|-> oc_pending)
		else $error("overcurrent recovery request lost");
	oc_clear_a: assert property (
		safety_pass_out && oc_pending && !overcurrent_set_in |=> !dsg_overcurrent_latch_out)
		else $error("overcurrent latch not cleared on safety pass");
	sc_clear_a: assert property (
		safety_pass_out && sc_pending && !short_set_in |=> !dsg_short_latch_out)
		else $error("short latch not cleared on safety pass");
	ls_restart_a: assert property (
		is_ls_restart && !load_sense_expired_out && !safety_pass_out && !is_ls_on
		|=> $stable(load_sense_pin_out))
		else $error("load sense restarted before expiry");
	ls_auto_a: assert property (
		(is_ls_on || is_ls_off) && autonomous && !safety_pass_out
		|=> $stable(load_sense_pin_out))
		else $error("load sense forced while autonomous");
	alert_low_a: assert property (
		is_low[PIN_ALERT] && pin_is_output_in[PIN_ALERT] |=> !pin_level_out[PIN_ALERT])
		else $error("alert pin not driven low");
	alert_high_a: assert property (
		is_high[PIN_ALERT] && pin_is_output_in[PIN_ALERT] |=> pin_level_out[PIN_ALERT])
		else $error("alert pin not driven high");
	pf_sequence_a: assert property (
		s_word_one ##1 s_quiet_then_two |=> permanent_failure_out)
		else $error("forced failure sequence not honoured");
	pf_only_seq_a: assert property (
		!permanent_failure_out ##1 permanent_failure_out |-> $past(pf_state) == COSD_PF_ARMED)
		else $error("forced failure without first word");
	swap_two_a: assert property (
		is_swap_two && !sealed |=> comm_type_out == COMM_TWO_WIRE_FAST && cfg_write_out
			&& cfg_write_data_out == COMM_TWO_WIRE_FAST)
		else $error("two-wire switch not applied");
	sealed_swap_a: assert property (
		swap_code && sealed && comm_loaded |=> $stable(comm_type_out) && !cfg_write_out
			&& cmd_reject_out)
		else $error("interface switch accepted while sealed");
	unknown_code_a: assert property (
		cmd_valid_in && !known && comm_loaded
		|=> $stable(pin_level_out) && $stable(comm_type_out) && !cfg_write_out && cmd_reject_out)
		else $error("unknown code changed state");
endmodule
`default_nettype wire

/* File: tb/cosd_host.sv */
/*
 * cosd_host: host controller model that offers command-only codes to the decoder.
 * Assumes the decoder takes a code on a rising edge and answers one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module cosd_host (
	input  wire logic                        mclk_in,
	input  wire logic                        cmd_done_in,
	input  wire logic                        cmd_reject_in,
	output var  logic                        cmd_valid_out,
	output var  logic [cosd_pkg::CODE_W-1:0] cmd_code_out,
	output var  logic                        other_write_out
);
	import cosd_pkg::*;

	initial begin
		cmd_valid_out   = 1'b0;
		cmd_code_out    = 16'h0000;
		other_write_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// offers one code after gap+1 idle cycles; answer is sampled one cycle later
	task automatic send(input logic [15:0] code, input int gap, output logic done,
			output logic rej);
		repeat (gap) @(negedge mclk_in);
		@(negedge mclk_in);
		cmd_valid_out = 1'b1;
		cmd_code_out  = code;
		@(negedge mclk_in);
		done          = cmd_done_in;
		rej           = cmd_reject_in;
		cmd_valid_out = 1'b0;
		// released code lines do not keep the last value
		cmd_code_out  = ~code;
	endtask

	task automatic other_write;
		@(negedge mclk_in);
		other_write_out = 1'b1;
		@(negedge mclk_in);
		other_write_out = 1'b0;
	endtask

	// two-word forced failure; brk puts another write between the words
	task automatic force_pair(input logic brk, input int gap);
		logic d;
		logic r;
		send(CODE_FORCED_WORD_ONE, 0, d, r);
		if (brk)
			other_write();
		send(CODE_FORCED_WORD_TWO, gap, d, r);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * tb_top: self-checking bench for the command-only subcommand decoder.
 * Assumes short safety period, forced window and load-sense counts set below.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("MISMATCH %s expected %h seen %h", name, exp, got); \
	end \
end
module tb_top;
	import cosd_pkg::*;

	logic       mclk = 1'b0;
	logic       rstn_n = 1'b0;
	logic [1:0] sec = SEC_UNSEALED;
	logic       oc_set = 1'b0;
	logic       sh_set = 1'b0;
	logic [7:0] ls_time = 8'h00;
	logic [5:0] pin_out = 6'h3f;
	logic [7:0] cfg = 8'h08;
	wire        valid, owr, done, rej, pass, oc, sc, ls_pin, ls_exp, pf, cfg_w;
	wire [15:0] code;
	wire [5:0]  pin_level, pin_drive;
	wire [7:0]  comm, cfg_data;
	int         bad_count = 0;
	int         n_compared = 0;

	always #50 mclk = ~mclk;

	cosd_decoder #(.SAFETY_CYCLES(20), .WINDOW_CYCLES(50), .LS_PASSES(2)) i_cosd_decoder (
		.mclk_in(mclk), .rstn_in(rstn_n), .cmd_valid_in(valid), .cmd_code_in(code),
		.other_write_in(owr), .security_state_in(sec), .overcurrent_set_in(oc_set),
		.short_set_in(sh_set), .load_sense_active_time_in(ls_time),
		.pin_is_output_in(pin_out), .comm_type_cfg_in(cfg), .cmd_done_out(done),
		.cmd_reject_out(rej), .safety_pass_out(pass), .dsg_overcurrent_latch_out(oc),
		.dsg_short_latch_out(sc), .load_sense_pin_out(ls_pin),
		.load_sense_expired_out(ls_exp), .pin_level_out(pin_level),
		.pin_drive_out(pin_drive), .permanent_failure_out(pf), .comm_type_out(comm),
		.cfg_write_out(cfg_w), .cfg_write_data_out(cfg_data));

	cosd_host i_cosd_host (.mclk_in(mclk), .cmd_done_in(done), .cmd_reject_in(rej),
		.cmd_valid_out(valid), .cmd_code_out(code), .other_write_out(owr));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmd(input logic [15:0] c, input logic ok);
		logic d;
		logic r;
		i_cosd_host.send(c, 0, d, r);
		`CHK("done", ok, d)
		`CHK("reject", ~ok, r)
	endtask

	task automatic wait_pass;
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (pass !== 1'b1 && n < 60);
		if (pass !== 1'b1) begin
			bad_count++;
			$display("MISMATCH safety pass expected 1 seen 0");
			wrap_up();
		end
	endtask

	task automatic t_pins;
		logic [5:0] e;
		e = 6'h00;
		for (int i = 0; i < 6; i++) begin
			cmd(PIN_HIGH_CODE[i], 1'b1);
			e[i] = 1'b1;
			`CHK("pin high", e, pin_level)
		end
		for (int i = 0; i < 6; i++) begin
			cmd(PIN_LOW_CODE[i], 1'b1);
			e[i] = 1'b0;
			`CHK("pin low", e, pin_level)
		end
		pin_out = 6'h3b;
		cmd(PIN_HIGH_CODE[PIN_ALERT], 1'b1);
		`CHK("pin not output", 6'h00, pin_level)
		`CHK("pin drive", 6'h3b, pin_drive)
		pin_out = 6'h3f;
	endtask

	task automatic t_recover;
		sec = SEC_SEALED;
		@(negedge mclk);
		oc_set = 1'b1;
		sh_set = 1'b1;
		@(negedge mclk);
		oc_set = 1'b0;
		sh_set = 1'b0;
		wait_pass();
		cmd(CODE_RECOVER_OVERCURRENT, 1'b1);
		`CHK("oc held", 1'b1, oc)
		wait_pass();
		@(negedge mclk);
		`CHK("oc cleared", 1'b0, oc)
		`CHK("short kept", 1'b1, sc)
		cmd(CODE_RECOVER_SHORT, 1'b1);
		wait_pass();
		@(negedge mclk);
		`CHK("short cleared", 1'b0, sc)
	endtask

	task automatic t_load;
		ls_time = 8'h05;
		cmd(CODE_LOAD_SENSE_ON, 1'b1);
		`CHK("ls autonomous on", 1'b0, ls_pin)
		ls_time = 8'h00;
		cmd(CODE_LOAD_SENSE_ON, 1'b1);
		`CHK("ls on", 1'b1, ls_pin)
		cmd(CODE_LOAD_SENSE_OFF, 1'b1);
		`CHK("ls off", 1'b0, ls_pin)
		cmd(CODE_LOAD_SENSE_RESTART, 1'b1);
		`CHK("ls restart early", 1'b0, ls_pin)
		cmd(CODE_LOAD_SENSE_ON, 1'b1);
		wait_pass();
		wait_pass();
		@(negedge mclk);
		`CHK("ls expired", 1'b1, ls_exp)
		`CHK("ls timed off", 1'b0, ls_pin)
		cmd(CODE_LOAD_SENSE_RESTART, 1'b1);
		`CHK("ls restarted", 1'b1, ls_pin)
		ls_time = 8'h05;
		cmd(CODE_LOAD_SENSE_OFF, 1'b1);
		`CHK("ls autonomous off", 1'b1, ls_pin)
	endtask

	task automatic t_comm;
		sec = SEC_SEALED;
		cfg = 8'h10;
		cmd(CODE_SWITCH_FOUR_WIRE, 1'b0);
		cmd(CODE_SWAP_STORED, 1'b0);
		cmd(CODE_SWITCH_SINGLE_WIRE, 1'b0);
		`CHK("sealed comm", 8'h08, comm)
		cmd(16'h1234, 1'b0);
		`CHK("unknown comm", 8'h08, comm)
		`CHK("unknown pins", 6'h00, pin_level)
		sec = SEC_UNSEALED;
		cmd(CODE_SWITCH_FOUR_WIRE, 1'b1);
		`CHK("four wire", 8'h10, comm)
		`CHK("four wire write", 1'b1, cfg_w)
		`CHK("four wire data", 8'h10, cfg_data)
		cmd(CODE_SWITCH_SINGLE_WIRE, 1'b1);
		`CHK("single wire", 8'h03, comm)
		`CHK("single wire data", 8'h03, cfg_data)
		sec = SEC_FULL_ACCESS;
		cmd(CODE_SWITCH_TWO_WIRE, 1'b1);
		`CHK("two wire", 8'h08, comm)
		`CHK("two wire data", 8'h08, cfg_data)
		cmd(CODE_SWAP_STORED, 1'b1);
		`CHK("stored type", 8'h10, comm)
	endtask

	task automatic t_forced;
		sec = SEC_SEALED;
		i_cosd_host.force_pair(1'b1, 0);
		`CHK("pair broken", 1'b0, pf)
		i_cosd_host.force_pair(1'b0, 60);
		`CHK("pair late", 1'b0, pf)
		i_cosd_host.force_pair(1'b0, 2);
		@(negedge mclk);
		`CHK("pair forced", 1'b1, pf)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge mclk);
		`CHK("reset comm", 8'h08, comm)
		rstn_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_pins();
		t_recover();
		t_load();
		t_comm();
		t_forced();
		wrap_up();
	end
endmodule
`default_nettype wire
